// ===== common/spims_pkg.sv
package spims_pkg;
	// Software register offsets on the plain port
	localparam logic [1:0] CTRL_OFS = 2'h0;
	localparam logic [1:0] STAT_OFS = 2'h1;
	localparam logic [1:0] DATA_OFS = 2'h2;
	localparam logic [1:0] PWR_OFS = 2'h3;
	// Control register fields
	localparam int CTRL_IRQEN_BIT = 7;
	localparam int CTRL_EN_BIT = 6;
	localparam int CTRL_ORDER_BIT = 5;
	localparam int CTRL_MASTER_SELECT_BIT_BIT = 4;
	localparam int CTRL_CPOL_BIT = 3;
	localparam int CTRL_CPHA_BIT = 2;
	// Status register fields
	localparam int STAT_DONE_BIT = 7;
	localparam int STAT_WRITE_COLLISION_FLAG_BIT = 6;
	localparam int STAT_X2_BIT = 0;
	// Power register: bit 0 gates the block, bit 1 makes select an input
	localparam int PWR_GATE_BIT = 0;
	localparam int PWR_SSIN_BIT = 1;
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] PWR_RST = 8'h01;
	// Bits per frame
	localparam logic [3:0] FRAME_BITS = 4'h8;
endpackage : spims_pkg

// ===== common/spims_if.sv
interface spims_if;
	logic sck;
	logic mosi;
	logic miso;
	logic misoOe;
	logic ssN;
	modport ctrl (output sck, output mosi, input miso, output ssN);
	modport periph (input sck, input mosi, output miso, output misoOe, input ssN);
endinterface : spims_if

// ===== rtl/spims_ctrl.sv
// Design decisions made here: the register addresses and the address-and-strobe port.
module spims_ctrl (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic [1:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [7:0] rdData,
	input wire logic [1:0] rate,
	input wire logic ssOut,
	input wire logic ssInPin,
	output logic irq,
	output logic wake,
	spims_if.ctrl bus
);
	logic [7:0] ctrlReg_r, pwrReg_r, shift_r, rxBuf_r;
	logic done_r, write_collision_flag_r, x2_r, armed_r, busy_r, sckInt_r, phase_r;
	logic [3:0] bitCnt_r;
	logic [6:0] divCnt_r;
	logic ss1_r, ss2_r, miso1_r, miso2_r, sampled_r;
	logic enabled, master, orderLsb, cpol, cpha, demote, finish, tick, dataAcc;
	logic [6:0] divTop;

	assign enabled = ctrlReg_r[spims_pkg::CTRL_EN_BIT] & ~pwrReg_r[spims_pkg::PWR_GATE_BIT];
	assign master = ctrlReg_r[spims_pkg::CTRL_MASTER_SELECT_BIT_BIT];
	assign orderLsb = ctrlReg_r[spims_pkg::CTRL_ORDER_BIT];
	assign cpol = ctrlReg_r[spims_pkg::CTRL_CPOL_BIT];
	assign cpha = ctrlReg_r[spims_pkg::CTRL_CPHA_BIT];
	assign dataAcc = (wrStb | rdStb) && addr == spims_pkg::DATA_OFS;

	// Select pin and MISO come from outside, so two flops first
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ss1_r <= 1'b1;
			ss2_r <= 1'b1;
			miso1_r <= 1'b0;
			miso2_r <= 1'b0;
		end else if (clkEn) begin
			ss1_r <= ssInPin;
			ss2_r <= ss1_r;
			miso1_r <= bus.miso;
			miso2_r <= miso1_r;
		end
	end

	// Another master pulling select low takes us off the bus
	assign demote = enabled && master && pwrReg_r[spims_pkg::PWR_SSIN_BIT] && !ss2_r;

	// Half-period divider: x2 gives /2,/8,/32,/64, else /4,/16,/64,/128
	always_comb begin
		case (rate)
			2'h0: divTop = x2_r ? 7'd0 : 7'd1;
			2'h1: divTop = x2_r ? 7'd3 : 7'd7;
			2'h2: divTop = x2_r ? 7'd15 : 7'd31;
			default: divTop = 7'd31 + (x2_r ? 7'd0 : 7'd32);
		endcase
	end
	assign tick = busy_r && divCnt_r == divTop;
	assign finish = tick && phase_r && bitCnt_r == spims_pkg::FRAME_BITS - 4'h1;

	// Registers; the hardware set beats the software clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrlReg_r <= spims_pkg::CTRL_RST;
			pwrReg_r <= spims_pkg::PWR_RST;
			x2_r <= 1'b0;
			done_r <= 1'b0;
			write_collision_flag_r <= 1'b0;
			armed_r <= 1'b0;
			rxBuf_r <= 8'h00;
		end else if (clkEn) begin
			if (wrStb && addr == spims_pkg::CTRL_OFS)
				ctrlReg_r <= wrData;
			else if (demote)
				ctrlReg_r[spims_pkg::CTRL_MASTER_SELECT_BIT_BIT] <= 1'b0;
			if (wrStb && addr == spims_pkg::PWR_OFS)
				pwrReg_r <= wrData;
			if (wrStb && addr == spims_pkg::STAT_OFS)
				x2_r <= wrData[spims_pkg::STAT_X2_BIT];
			if (rdStb && addr == spims_pkg::STAT_OFS)
				armed_r <= done_r | write_collision_flag_r;
			else if (dataAcc)
				armed_r <= 1'b0;
			if (finish || demote)
				done_r <= 1'b1;
			else if (dataAcc && armed_r)
				done_r <= 1'b0;
			if (wrStb && addr == spims_pkg::DATA_OFS && busy_r)
				write_collision_flag_r <= 1'b1;
			else if (dataAcc && armed_r)
				write_collision_flag_r <= 1'b0;
			if (finish)
				rxBuf_r <= orderLsb ? {sampled_r, shift_r[7:1]} : {shift_r[6:0], sampled_r};
		end
	end

	// Shift engine; phase_r=0 marks the sampling half
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_r <= 1'b0;
			sckInt_r <= 1'b0;
			phase_r <= 1'b0;
			bitCnt_r <= 4'h0;
			divCnt_r <= 7'd0;
			shift_r <= 8'h00;
			sampled_r <= 1'b0;
		end else if (clkEn) begin
			if (!enabled || !master || demote) begin
				busy_r <= 1'b0;
				sckInt_r <= 1'b0;
			end else if (!busy_r) begin
				if (wrStb && addr == spims_pkg::DATA_OFS) begin
					busy_r <= 1'b1;
					shift_r <= wrData;
					bitCnt_r <= 4'h0;
					divCnt_r <= 7'd0;
					phase_r <= 1'b0;
				end
			end else if (tick) begin
				divCnt_r <= 7'd0;
				sckInt_r <= ~sckInt_r;
				phase_r <= ~phase_r;
				if (!phase_r) begin
					sampled_r <= miso2_r;
				end else begin
					bitCnt_r <= bitCnt_r + 4'h1;
					if (finish) begin
						busy_r <= 1'b0;
						sckInt_r <= 1'b0;
					end else
						shift_r <= orderLsb ? {sampled_r, shift_r[7:1]} : {shift_r[6:0], sampled_r};
				end
			end else
				divCnt_r <= divCnt_r + 7'd1;
		end
	end

	// CPHA=1 inverts the clock while busy, so each bit opens on a setup edge
	logic moBit;
	assign moBit = orderLsb ? shift_r[0] : shift_r[7];
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.mosi <= 1'b0;
			bus.sck <= 1'b0;
			bus.ssN <= 1'b1;
			rdData <= 8'h00;
		end else if (clkEn) begin
			bus.sck <= (busy_r ? (cpha ? ~sckInt_r : sckInt_r) : 1'b0) ^ cpol;
			bus.mosi <= moBit;
			bus.ssN <= ssOut;
			if (rdStb) begin
				if (addr == spims_pkg::CTRL_OFS)
					rdData <= ctrlReg_r;
				else if (addr == spims_pkg::STAT_OFS)
					rdData <= {done_r, write_collision_flag_r, 5'b00000, x2_r};
				else if (addr == spims_pkg::DATA_OFS)
					rdData <= rxBuf_r;
				else
					rdData <= pwrReg_r;
			end else
				rdData <= 8'h00;
		end
	end

	assign irq = done_r & ctrlReg_r[spims_pkg::CTRL_IRQEN_BIT];
	assign wake = irq;
endmodule : spims_ctrl

// ===== rtl/spims_periph.sv
// Slave end: samples the link clock with ref_clk
module spims_periph (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic [1:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [7:0] rdData,
	input wire logic misoDrvEn,
	output logic irq,
	output logic wake,
	spims_if.periph bus
);
	logic [7:0] ctrlReg_r, pwrReg_r, shift_r, rxBuf_r, txData_r;
	logic done_r, write_collision_flag_r, x2_r, armed_r, sck3_r, sampled_r;
	logic [3:0] bitCnt_r;
	logic sck1_r, sck2_r, mosi1_r, mosi2_r, ss1_r, ss2_r;
	logic enabled, orderLsb, cpol, cpha, active, lead, trail, sampleEdge, setupEdge;
	logic dataAcc, finish, sclk, sclkPrev;

	assign enabled = ctrlReg_r[spims_pkg::CTRL_EN_BIT] & ~pwrReg_r[spims_pkg::PWR_GATE_BIT];
	assign orderLsb = ctrlReg_r[spims_pkg::CTRL_ORDER_BIT];
	assign cpol = ctrlReg_r[spims_pkg::CTRL_CPOL_BIT];
	assign cpha = ctrlReg_r[spims_pkg::CTRL_CPHA_BIT];
	assign active = enabled && !ss2_r;
	assign dataAcc = (wrStb | rdStb) && addr == spims_pkg::DATA_OFS;

	// Link pins pass two flops; phases must exceed two cycles
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sck1_r <= 1'b0;
			sck2_r <= 1'b0;
			sck3_r <= 1'b0;
			mosi1_r <= 1'b0;
			mosi2_r <= 1'b0;
			ss1_r <= 1'b1;
			ss2_r <= 1'b1;
		end else if (clkEn) begin
			sck1_r <= bus.sck;
			sck2_r <= sck1_r;
			sck3_r <= sck2_r;
			mosi1_r <= bus.mosi;
			mosi2_r <= mosi1_r;
			ss1_r <= bus.ssN;
			ss2_r <= ss1_r;
		end
	end

	assign sclk = sck2_r ^ cpol;
	assign sclkPrev = sck3_r ^ cpol;
	assign lead = sclk & ~sclkPrev;
	assign trail = ~sclk & sclkPrev;
	assign sampleEdge = active && (cpha ? trail : lead);
	assign setupEdge = active && (cpha ? lead : trail);
	assign finish = sampleEdge && bitCnt_r == spims_pkg::FRAME_BITS - 4'h1;

	// Shifter; select high clears the count and partial byte
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_r <= 8'h00;
			bitCnt_r <= 4'h0;
			sampled_r <= 1'b0;
		end else if (clkEn) begin
			if (!active) begin
				bitCnt_r <= 4'h0;
				shift_r <= txData_r;
			end else if (sampleEdge) begin
				sampled_r <= mosi2_r;
				bitCnt_r <= finish ? 4'h0 : bitCnt_r + 4'h1;
				if (finish)
					shift_r <= txData_r;
			end else if (setupEdge && bitCnt_r != 4'h0)
				shift_r <= orderLsb ? {sampled_r, shift_r[7:1]} : {shift_r[6:0], sampled_r};
		end
	end

	// Registers; hardware set wins over the clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrlReg_r <= spims_pkg::CTRL_RST;
			pwrReg_r <= spims_pkg::PWR_RST;
			x2_r <= 1'b0;
			done_r <= 1'b0;
			write_collision_flag_r <= 1'b0;
			armed_r <= 1'b0;
			rxBuf_r <= 8'h00;
			txData_r <= 8'h00;
		end else if (clkEn) begin
			if (wrStb && addr == spims_pkg::CTRL_OFS)
				ctrlReg_r <= wrData;
			if (wrStb && addr == spims_pkg::PWR_OFS)
				pwrReg_r <= wrData;
			if (wrStb && addr == spims_pkg::STAT_OFS)
				x2_r <= wrData[spims_pkg::STAT_X2_BIT];
			if (wrStb && addr == spims_pkg::DATA_OFS) begin
				if (active && bitCnt_r != 4'h0)
					write_collision_flag_r <= 1'b1;
				else begin
					txData_r <= wrData;
					// An accepted write is a data access too, so it clears
					if (armed_r)
						write_collision_flag_r <= 1'b0;
				end
			end else if (dataAcc && armed_r)
				write_collision_flag_r <= 1'b0;
			if (rdStb && addr == spims_pkg::STAT_OFS)
				armed_r <= done_r | write_collision_flag_r;
			else if (dataAcc)
				armed_r <= 1'b0;
			if (finish)
				done_r <= 1'b1;
			else if (dataAcc && armed_r)
				done_r <= 1'b0;
			if (finish)
				rxBuf_r <= orderLsb ? {mosi2_r, shift_r[7:1]} : {shift_r[6:0], mosi2_r};
		end
	end

	// MISO driven only while selected and allowed by software
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.miso <= 1'b0;
			bus.misoOe <= 1'b0;
			rdData <= 8'h00;
		end else if (clkEn) begin
			bus.miso <= orderLsb ? shift_r[0] : shift_r[7];
			bus.misoOe <= active & misoDrvEn;
			if (rdStb) begin
				if (addr == spims_pkg::CTRL_OFS)
					rdData <= ctrlReg_r;
				else if (addr == spims_pkg::STAT_OFS)
					rdData <= {done_r, write_collision_flag_r, 5'b00000, x2_r};
				else if (addr == spims_pkg::DATA_OFS)
					rdData <= rxBuf_r;
				else
					rdData <= pwrReg_r;
			end else
				rdData <= 8'h00;
		end
	end

	assign irq = done_r & ctrlReg_r[spims_pkg::CTRL_IRQEN_BIT];
	assign wake = irq;
endmodule : spims_periph

// ===== bench/spims_assertions.sv
module spims_chk (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic misoOe,
	input wire logic ssN
);
	timeunit 1ns;
	timeprecision 100ps;
	logic sckQ_r;
	logic [7:0] idleCnt_r;
	logic [2:0] edgeCnt_r;
	// Cycles since the link clock last moved; saturates so it never wraps to zero
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sckQ_r <= 1'b0;
			idleCnt_r <= 8'h00;
		end else begin
			sckQ_r <= sck;
			idleCnt_r <= (sck != sckQ_r) ? 8'h00 : idleCnt_r + {7'h00, idleCnt_r != 8'hFF};
		end
	end
	// Rising clock edges inside one selection, modulo one byte
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			edgeCnt_r <= 3'h0;
		else
			edgeCnt_r <= ssN ? 3'h0 : edgeCnt_r + {2'h0, sck & ~sckQ_r};
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Slave output follows its select, with the synchroniser lag
	a_oe_needs_sel: assert property ($rose(misoOe) |-> !ssN && !$past(ssN))
		else $error("slave output enabled without select");
	a_oe_drop_desel: assert property ($fell(misoOe) |-> $past(ssN))
		else $error("slave output dropped while selected");
	a_oe_off_desel: assert property (ssN [*6] |-> !misoOe)
		else $error("slave output driven while deselected");
	// Bench runs modes 0 and 3 only, so sampling is always on the rising edge
	a_mosi_settled: assert property (!ssN && $rose(sck) |-> $stable(mosi))
		else $error("master data moved at sampling edge");
	a_miso_settled: assert property (misoOe && $rose(sck) |-> $stable(miso))
		else $error("slave data moved at sampling edge");
	a_sck_phase_min: assert property (!ssN && $changed(sck) |=> $stable(sck) [*3])
		else $error("link clock phase too short");
	// A quiet selected link must sit on a byte boundary
	a_byte_whole: assert property (!ssN && idleCnt_r == 8'hC8 |-> edgeCnt_r == 3'h0)
		else $error("clock stopped in mid-byte");
	a_half_bound: assert property (!ssN && edgeCnt_r != 3'h0 |-> idleCnt_r < 8'h41)
		else $error("half period above slowest rate");
	c_slave_drives: cover property ($rose(misoOe));
	c_frame_start: cover property ($fell(ssN) ##[1:300] $rose(sck));
	c_fast_clock: cover property ($changed(sck) ##1 $changed(sck));
endmodule : spims_chk

// ===== bench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [1:0] CT = spims_pkg::CTRL_OFS, ST = spims_pkg::STAT_OFS;
	localparam logic [1:0] DT = spims_pkg::DATA_OFS, PW = spims_pkg::PWR_OFS;
	logic ref_clk = 1'b0, rst_b = 1'b0, mSs = 1'b1, ssIn = 1'b1, sDrv = 1'b1;
	logic [1:0] mRate = 2'h1;
	logic [1:0] a [2] = '{2'h0, 2'h0};
	logic [7:0] d [2] = '{8'h00, 8'h00};
	logic w [2] = '{1'b0, 1'b0};
	logic r [2] = '{1'b0, 1'b0};
	wire [7:0] q [2];
	wire [1:0] irq, wake;
	logic [7:0] rv;
	int n_mismatch = 0, total_checks = 0;
	// Master ctrl, slave ctrl, master tx, slave tx, master rx, slave rx
	logic [7:0] tab [3][6] = '{'{8'hD0, 8'hC0, 8'hA5, 8'h3C, 8'h3C, 8'hA5},
		'{8'hF0, 8'hC0, 8'h12, 8'h0F, 8'hF0, 8'h48}, '{8'hDC, 8'hCC, 8'h96, 8'h69, 8'h69, 8'h96}};
	logic [7:0] dv [8] = '{8'h04, 8'h10, 8'h40, 8'h80, 8'h02, 8'h08, 8'h20, 8'h40};
	spims_if lnk ();
	always #5 ref_clk = ~ref_clk;
	spims_ctrl u_spims_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .clkEn(1'b1), .addr(a[0]),
		.wrData(d[0]), .wrStb(w[0]), .rdStb(r[0]), .rdData(q[0]), .rate(mRate), .ssOut(mSs),
		.ssInPin(ssIn), .irq(irq[0]), .wake(wake[0]), .bus(lnk.ctrl));
	spims_periph u_spims_periph (.ref_clk(ref_clk), .rst_b(rst_b), .clkEn(1'b1), .addr(a[1]),
		.wrData(d[1]), .wrStb(w[1]), .rdStb(r[1]), .rdData(q[1]), .misoDrvEn(sDrv),
		.irq(irq[1]), .wake(wake[1]), .bus(lnk.periph));
	spims_chk u_spims_chk (.ref_clk(ref_clk), .rst_b(rst_b), .sck(lnk.sck), .mosi(lnk.mosi),
		.miso(lnk.miso), .misoOe(lnk.misoOe), .ssN(lnk.ssN));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	// One strobe cycle, then read data taken in the single cycle it stands
	task automatic acc(input int e, input logic [1:0] ad, input logic [7:0] dt, input logic rd);
		@(posedge ref_clk);
		a[e] <= ad;
		d[e] <= dt;
		w[e] <= ~rd;
		r[e] <= rd;
		@(posedge ref_clk);
		w[e] <= 1'b0;
		r[e] <= 1'b0;
		#1 rv = q[e];
	endtask : acc
	task automatic wr(input int e, input logic [1:0] ad, input logic [7:0] dt);
		acc(e, ad, dt, 1'b0);
	endtask : wr
	task automatic rc(input int e, input logic [1:0] ad, input logic [7:0] ex);
		acc(e, ad, 8'h00, 1'b1);
		chk(rv, ex);
	endtask : rc
	// Poll the master done flag; a hang ends the run
	task automatic wdone();
		rv = 8'h00;
		for (int i = 0; i < 2000 && rv[7] !== 1'b1; i++)
			acc(0, ST, 8'h00, 1'b1);
		if (rv[7] !== 1'b1) begin
			n_mismatch++;
			give_verdict();
		end
	endtask : wdone
	task automatic frame(input logic [7:0] m);
		wr(0, DT, m);
		wdone();
	endtask : frame
	task automatic srx(input logic [7:0] e);
		rc(1, ST, 8'h80);
		chk({6'h00, wake[1], irq[1]}, 8'h03);
		rc(1, DT, e);
	endtask : srx
	// Slave byte is loaded while deselected, so it must wait for select
	task automatic xfer(input logic [7:0] m, input logic [7:0] s, input logic [7:0] em,
		input logic [7:0] es);
		wr(1, DT, s);
		@(posedge ref_clk);
		mSs <= 1'b0;
		frame(m);
		chk({6'h00, wake[0], irq[0]}, 8'h03);
		rc(0, DT, em);
		srx(es);
		chk({4'h0, wake, irq}, 8'h00);
		@(posedge ref_clk);
		mSs <= 1'b1;
	endtask : xfer
	initial begin
		int n;
		int c;
		logic p;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		// Reset values, then a gated master must stay silent
		for (int e = 0; e < 2; e++) begin
			rc(e, CT, spims_pkg::CTRL_RST);
			rc(e, ST, spims_pkg::STAT_RST);
			rc(e, PW, spims_pkg::PWR_RST);
		end
		wr(0, CT, 8'hD0);
		wr(0, DT, 8'h5A);
		repeat (40) @(posedge ref_clk);
		rc(0, ST, 8'h00);
		wr(0, PW, 8'h00);
		wr(1, PW, 8'h00);
		$display("-- reset and gating done");
		// Clock modes and bit orders, idle level checked first
		for (int k = 0; k < 3; k++) begin
			wr(0, CT, tab[k][0]);
			wr(1, CT, tab[k][1]);
			chk({7'h00, lnk.sck}, {7'h00, tab[k][0][3]});
			xfer(tab[k][2], tab[k][3], tab[k][4], tab[k][5]);
		end
		wr(0, CT, 8'hD0);
		wr(1, CT, 8'hC0);
		$display("-- modes done");
		// Busy write refused and flagged; unread slave byte overwritten
		@(posedge ref_clk);
		mSs <= 1'b0;
		wr(0, DT, 8'h11);
		frame(8'h22);
		chk(rv, 8'hC0);
		acc(0, DT, 8'h00, 1'b1);
		rc(0, ST, 8'h00);
		srx(8'h11);
		frame(8'h5C);
		acc(0, DT, 8'h00, 1'b1);
		frame(8'hC5);
		acc(0, DT, 8'h00, 1'b1);
		srx(8'hC5);
		// Select raised mid-byte drops the partial byte
		wr(0, DT, 8'hFF);
		repeat (60) @(posedge ref_clk);
		mSs <= 1'b1;
		wdone();
		acc(0, DT, 8'h00, 1'b1);
		rc(1, ST, 8'h00);
		xfer(8'h3A, 8'hC3, 8'hC3, 8'h3A);
		$display("-- buffering done");
		// Selected slave holds MISO released until software allows it
		repeat (8) @(posedge ref_clk);
		sDrv <= 1'b0;
		mSs <= 1'b0;
		repeat (210) @(posedge ref_clk);
		#1 chk({7'h00, lnk.misoOe}, 8'h00);
		@(posedge ref_clk);
		sDrv <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1 chk({7'h00, lnk.misoOe}, 8'h01);
		@(posedge ref_clk);
		mSs <= 1'b1;
		$display("-- output enable done");
		// Rise-to-rise period of the master clock, no slave selected
		for (int k = 0; k < 8; k++) begin
			wr(0, ST, {7'h00, k[2]});
			@(posedge ref_clk);
			mRate <= k[1:0];
			wr(0, DT, 8'h00);
			n = 0;
			c = 0;
			p = lnk.sck;
			for (int i = 0; i < 600 && n < 2; i++) begin
				@(posedge ref_clk);
				#1;
				c += int'(n == 1);
				n += int'(lnk.sck & ~p);
				p = lnk.sck;
			end
			chk(c[7:0], dv[k]);
			if (n < 2) begin
				n_mismatch++;
				give_verdict();
			end
			wdone();
			acc(0, DT, 8'h00, 1'b1);
		end
		$display("-- rates done");
		// Select input pulled low turns the master into a slave
		wr(0, PW, 8'h02);
		@(posedge ref_clk);
		ssIn <= 1'b0;
		repeat (6) @(posedge ref_clk);
		rc(0, CT, 8'hC0);
		rc(0, ST, 8'h81);
		$display("-- demotion done");
		give_verdict();
	end
endmodule : tb
